/* core/status_and_system_config_regs.sv */
// Purpose : Status register and first system configuration registers
//           behind the parallel host port of the display controller.
// Assumes : Host pins are asynchronous to i_mclk and each cycle holds
//           chip select low for several clock periods.
// Notes   : Writes take effect when chip select returns high; read data
//           is loaded when chip select falls.
`include "regbank_consts.svh"

// Summary of operation
// - Status bit 7 shows memory access busy
// - Status bit 6 shows block transfer busy
// - Status bit 5 mirrors raw touch detect
// - Status bit 4 shows sleep mode
// - Status bit 0 serial memory busy
// - Sleep bit enters; touch, key, software wake
// - Sleep unsupported over two-wire host link
// - Port writes go to chosen memory target
// - Port reads pipelined, first read dummy
// - Bit 7 picks pixel sampling edge
// - Pixel period 1, 2, 4, 8 clocks
// - Bit 7 picks serial memory interface
// - Bit 5 picks serial waveform mode
// - Read length four, five, six bytes
// - Bit 2 routes serial font or DMA
// - Bits 1:0 pick single or dual latch
// - Status read needs no register number
// - Command write selects register for data
module status_and_system_config_regs
  import regbank_pkg::*;
#(
  parameter int BUF_DEPTH = 2,
  parameter int PIX_CNT_W = 3
) (
  // Clock and reset
  input  logic                  i_mclk,
  input  logic                  i_rst_b,
  // Host port pins
  input  logic                  i_cs_b,
  input  logic                  i_rw_b,
  input  logic                  i_rs,
  input  logic [7:0]            i_db,
  output logic [7:0]            o_db,
  output logic                  o_db_oe,
  output logic                  o_wait_b,
  // Host link mode and touch pins
  input  logic                  i_i2c_mode,
  input  logic                  i_touch_detect_raw,
  // Memory write side
  input  logic [1:0]            i_mem_target,
  output logic                  o_mem_wr_valid,
  output mem_write_s            o_mem_wr,
  input  logic                  i_mem_wr_ready,
  // Memory read side
  output logic                  o_mem_rd_req,
  input  logic                  i_mem_rd_valid,
  input  logic [7:0]            i_mem_rd_data,
  // Engine state and wake events
  input  logic                  i_font_busy,
  input  logic                  i_bte_busy,
  input  logic                  i_sf_busy,
  input  logic                  i_touch_wake,
  input  logic                  i_key_wake,
  // Configuration outputs
  output logic                  o_display_on,
  output logic                  o_sleep,
  output logic                  o_soft_reset,
  output logic                  o_pixel_en,
  output logic                  o_pixel_fall_edge,
  output serial_memory_config_s o_serial_memory_config,
  output serial_read_format_s   o_serial_read_format
);
  localparam int WR_W = $bits(mem_write_s);

  logic                  cs_meta_reg;
  logic                  cs_sync_reg;
  logic                  cs_prev_reg;
  host_pins_s            pins_meta_reg;
  host_pins_s            pins_sync_reg;
  host_pins_s            hold_reg;
  logic [1:0]            mode_meta_reg;
  logic [1:0]            mode_sync_reg;
  logic                  i2c_sync;
  logic                  touch_sync;
  host_phase_e           phase_reg;
  host_phase_e           phase_next;
  logic                  cycle_start;
  logic                  cycle_end;
  logic                  cmd_write;
  logic                  data_write;
  logic                  status_read;
  logic                  data_read_start;
  logic                  data_read_end;
  logic [7:0]            index_reg;
  logic                  port_sel;
  logic                  port_write;
  logic                  pwr_write;
  logic                  sw_reset_armed_reg;
  logic                  soft_clear_reg;
  logic                  display_on_reg;
  logic                  sleep_reg;
  logic                  pixel_invert_reg;
  logic [1:0]            pixel_div_reg;
  serial_memory_config_s serial_memory_config_reg;
  serial_read_format_s   read_format_reg;
  logic                  buf_in_ready;
  logic                  rd_req_reg;
  logic                  rd_pending_reg;
  logic [7:0]            rd_data_reg;
  logic [7:0]            db_reg;
  device_status_s        status_now;
  logic [7:0]            read_value;

  function automatic serial_read_format_s decode_read_format(
    input serial_memory_config_s cfg
  );
    serial_read_format_s fmt;
    fmt.dummy_bytes = cfg.read_cycle[1] ? 2'h2 : {1'h0, cfg.read_cycle[0]};
    fmt.bus_bytes   = `SF_BASE_BUS_BYTES + {1'h0, fmt.dummy_bytes};
    fmt.dual        = cfg.latch_mode[1];
    fmt.dual_mode1  = cfg.latch_mode[1] & cfg.latch_mode[0];
    return fmt;
  endfunction

  // Two-stage synchronisers for every pin
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cs_meta_reg   <= 1'h1;
      cs_sync_reg   <= 1'h1;
      cs_prev_reg   <= 1'h1;
      pins_meta_reg <= '0;
      pins_sync_reg <= '0;
      mode_meta_reg <= 2'h0;
      mode_sync_reg <= 2'h0;
    end else begin
      cs_meta_reg   <= i_cs_b;
      cs_sync_reg   <= cs_meta_reg;
      cs_prev_reg   <= cs_sync_reg;
      pins_meta_reg <= '{rw_b: i_rw_b, rs: i_rs, data: i_db};
      pins_sync_reg <= pins_meta_reg;
      mode_meta_reg <= {i_i2c_mode, i_touch_detect_raw};
      mode_sync_reg <= mode_meta_reg;
    end
  end

  assign i2c_sync   = mode_sync_reg[1];
  assign touch_sync = mode_sync_reg[0];

  // Last pin values seen while chip select was low
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      hold_reg <= '0;
    end else if (!cs_sync_reg) begin
      hold_reg <= pins_sync_reg;
    end
  end

  assign cycle_start = cs_prev_reg & ~cs_sync_reg;
  assign cycle_end   = ~cs_prev_reg & cs_sync_reg;

  always_comb begin
    phase_next = phase_reg;
    unique case (phase_reg)
      HOST_IDLE: begin
        if (cycle_start) begin
          phase_next = pins_sync_reg.rw_b ? HOST_READ : HOST_WRITE;
        end
      end
      HOST_READ, HOST_WRITE: begin
        if (cycle_end) begin
          phase_next = HOST_IDLE;
        end
      end
      default: phase_next = HOST_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      phase_reg <= HOST_IDLE;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // Cycle types from the read/write and register select lines
  assign cmd_write       = cycle_end & (phase_reg == HOST_WRITE) & hold_reg.rs;
  assign data_write      = cycle_end & (phase_reg == HOST_WRITE) & ~hold_reg.rs;
  assign status_read     = cycle_start & (phase_reg == HOST_IDLE)
                           & pins_sync_reg.rw_b & pins_sync_reg.rs;
  assign data_read_start = cycle_start & (phase_reg == HOST_IDLE)
                           & pins_sync_reg.rw_b & ~pins_sync_reg.rs;
  assign data_read_end   = cycle_end & (phase_reg == HOST_READ) & ~hold_reg.rs;
  assign port_sel        = (index_reg == `REG_MEMORY_DATA);
  assign port_write      = data_write & port_sel;
  assign pwr_write       = data_write & (index_reg == `REG_POWER_DISPLAY);

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      index_reg <= `RESET_INDEX;
    end else if (soft_clear_reg) begin
      index_reg <= `RESET_INDEX;
    end else if (cmd_write) begin
      index_reg <= hold_reg.data;
    end
  end

  // Software reset fires when a one is followed by a zero
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sw_reset_armed_reg <= 1'h0;
      soft_clear_reg     <= 1'h0;
    end else begin
      soft_clear_reg <= pwr_write & ~hold_reg.data[`PWR_SW_RESET_BIT]
                        & sw_reset_armed_reg;
      if (soft_clear_reg) begin
        sw_reset_armed_reg <= 1'h0;
      end else if (pwr_write) begin
        sw_reset_armed_reg <= hold_reg.data[`PWR_SW_RESET_BIT];
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      display_on_reg <= `RESET_DISPLAY_ON;
    end else if (soft_clear_reg) begin
      display_on_reg <= `RESET_DISPLAY_ON;
    end else if (pwr_write) begin
      display_on_reg <= hold_reg.data[`PWR_DISPLAY_ON_BIT];
    end
  end

  // Sleep writes are ignored when the host uses the two-wire link
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sleep_reg <= `RESET_SLEEP;
    end else if (soft_clear_reg) begin
      sleep_reg <= `RESET_SLEEP;
    end else if (pwr_write && !i2c_sync) begin
      sleep_reg <= hold_reg.data[`PWR_SLEEP_BIT];
    end else if (i_touch_wake || i_key_wake) begin
      sleep_reg <= 1'h0;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pixel_invert_reg <= `RESET_PIX_INVERT;
      pixel_div_reg    <= `RESET_PIX_DIV;
    end else if (soft_clear_reg) begin
      pixel_invert_reg <= `RESET_PIX_INVERT;
      pixel_div_reg    <= `RESET_PIX_DIV;
    end else if (data_write && index_reg == `REG_PIXEL_CLOCK) begin
      pixel_invert_reg <= hold_reg.data[`PIX_INVERT_BIT];
      pixel_div_reg    <= hold_reg.data[`PIX_DIV_LSB +: 2];
    end
  end

  // Serial memory options stored as written, decoded one clock later
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      serial_memory_config_reg        <= serial_memory_config_s'(`RESET_SERIAL_MEMORY);
      read_format_reg <= '0;
    end else begin
      read_format_reg <= decode_read_format(serial_memory_config_reg);
      if (soft_clear_reg) begin
        serial_memory_config_reg <= serial_memory_config_s'(`RESET_SERIAL_MEMORY);
      end else if (data_write && index_reg == `REG_SERIAL_MEMORY) begin
        serial_memory_config_reg <= serial_memory_config_s'(hold_reg.data);
      end
    end
  end

  mem_port_buffer #(
    .W     (WR_W),
    .DEPTH (BUF_DEPTH)
  ) u_write_buffer (
    .i_mclk      (i_mclk),
    .i_rst_b     (i_rst_b),
    .i_clear     (soft_clear_reg),
    .i_in_valid  (port_write),
    .i_in_data   ({i_mem_target, hold_reg.data}),
    .o_in_ready  (buf_in_ready),
    .o_out_valid (o_mem_wr_valid),
    .o_out_data  (o_mem_wr),
    .i_out_ready (i_mem_wr_ready)
  );

  // Each port read asks for the next byte; the first answer is stale
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rd_req_reg     <= 1'h0;
      rd_pending_reg <= 1'h0;
      rd_data_reg    <= 8'h00;
    end else if (soft_clear_reg) begin
      rd_req_reg     <= 1'h0;
      rd_pending_reg <= 1'h0;
      rd_data_reg    <= 8'h00;
    end else begin
      rd_req_reg     <= data_read_end & port_sel;
      rd_pending_reg <= (data_read_end & port_sel) | (rd_pending_reg & ~i_mem_rd_valid);
      if (i_mem_rd_valid) begin
        rd_data_reg <= i_mem_rd_data;
      end
    end
  end

  assign status_now = '{
    mem_busy: o_mem_wr_valid | rd_pending_reg | i_font_busy,
    bte_busy: i_bte_busy,
    touch:    touch_sync,
    sleep:    sleep_reg,
    unused:   3'h0,
    sf_busy:  i_sf_busy
  };

  always_comb begin
    read_value = `UNMAPPED_READ;
    case (index_reg)
      `REG_POWER_DISPLAY: read_value = {display_on_reg, 5'h00, sleep_reg, 1'h0};
      `REG_MEMORY_DATA:   read_value = rd_data_reg;
      `REG_PIXEL_CLOCK:   read_value = {pixel_invert_reg, 5'h00, pixel_div_reg};
      `REG_SERIAL_MEMORY: read_value = serial_memory_config_reg;
      default:            read_value = `UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      db_reg <= 8'h00;
    end else if (status_read) begin
      db_reg <= status_now;
    end else if (data_read_start) begin
      db_reg <= read_value;
    end else if (phase_reg == HOST_READ && !hold_reg.rs && port_sel && i_mem_rd_valid) begin
      db_reg <= i_mem_rd_data;
    end
  end

  assign o_db    = db_reg;
  assign o_db_oe = (phase_reg == HOST_READ);
  // Hold the host while the write buffer is full or a port byte is due
  assign o_wait_b = ~(((phase_reg == HOST_WRITE) & ~hold_reg.rs & port_sel & ~buf_in_ready)
                    | ((phase_reg == HOST_READ) & ~hold_reg.rs & port_sel & rd_pending_reg));

  assign o_display_on           = display_on_reg;
  assign o_sleep                = sleep_reg;
  assign o_soft_reset           = soft_clear_reg;
  assign o_pixel_fall_edge      = pixel_invert_reg;
  assign o_serial_memory_config = serial_memory_config_reg;
  assign o_serial_read_format   = read_format_reg;
  assign o_mem_rd_req           = rd_req_reg;

  pixel_clock_div #(
    .CODE_W (2),
    .CNT_W  (PIX_CNT_W)
  ) u_pixel_div (
    .i_mclk        (i_mclk),
    .i_rst_b       (i_rst_b),
    .i_clear       (soft_clear_reg),
    .i_period_code (pixel_div_reg),
    .o_pixel_en    (o_pixel_en)
  );

  default clocking chk_cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_b);

  chk_read_busy_flag: assert property (
    (data_read_end && port_sel && !soft_clear_reg) |=> status_now.mem_busy
  ) else $error("memory busy flag low after a port read");

  chk_bte_status_read: assert property (
    (status_read && i_bte_busy) |=> (o_db_oe && o_db[6])
  ) else $error("block transfer busy not shown in status read");

  chk_touch_mirror: assert property (
    i_touch_detect_raw [*3] |-> status_now.touch
  ) else $error("touch flag does not follow raw touch pin");

  chk_sleep_flag_read: assert property (
    status_read |=> (o_db[4] == $past(sleep_reg))
  ) else $error("sleep flag wrong in status read");

  chk_status_low_bits: assert property (
    status_read |=> (o_db[3:1] == 3'h0 && o_db[0] == $past(i_sf_busy))
  ) else $error("status bits three to zero wrong");

  chk_sleep_entry: assert property (
    (pwr_write && hold_reg.data[1] && !i2c_sync && !soft_clear_reg) |=> o_sleep
  ) else $error("sleep not entered after sleep write");

  chk_wake_event: assert property (
    (o_sleep && (i_touch_wake || i_key_wake) && !pwr_write && !soft_clear_reg) |=> !o_sleep
  ) else $error("wake event did not leave sleep");

  chk_sleep_two_wire: assert property (
    (i2c_sync && !o_sleep) |=> !o_sleep
  ) else $error("sleep entered over two-wire host link");

  chk_port_write_push: assert property (
    (port_write && buf_in_ready && !soft_clear_reg) |=> o_mem_wr_valid
  ) else $error("port write not passed to memory side");

  chk_port_read_fetch: assert property (
    (data_read_end && port_sel && !soft_clear_reg) |=> o_mem_rd_req ##1 !o_mem_rd_req
  ) else $error("port read did not request exactly one byte");

  chk_pixel_period_eight: assert property (
    (o_pixel_en && pixel_div_reg == 2'h3)
      ##1 (pixel_div_reg == 2'h3 && !soft_clear_reg) [*7] |=> o_pixel_en
  ) else $error("pixel enable period not eight clocks");

  chk_read_format: assert property (
    (serial_memory_config_reg.read_cycle == 2'h1) [*2] |->
      (read_format_reg.bus_bytes == 3'h5 && read_format_reg.dummy_bytes == 2'h1)
  ) else $error("serial read length decode wrong");

  chk_soft_reset_state: assert property (
    soft_clear_reg |=> (!o_display_on && !o_sleep && serial_memory_config_reg == '0 && index_reg == 8'h00)
  ) else $error("software reset left state behind");

  cov_sleep_wake: cover property (o_sleep ##[1:200] !o_sleep);
  cov_soft_reset: cover property (soft_clear_reg);
  cov_write_stall: cover property ((phase_reg == HOST_WRITE) && !o_wait_b);
  cov_port_writes: cover property (port_write ##[1:40] port_write);

endmodule

/* core/regbank_consts.svh */
// Purpose : Register numbers, field positions and reset values of the
//           status and system configuration register bank.
// Assumes : Included by the bank's design files and by the testbench.
// Notes   : Register numbers are the 8-bit values written by a command cycle.
`ifndef REGBANK_CONSTS_SVH
`define REGBANK_CONSTS_SVH

// Register numbers
`define REG_POWER_DISPLAY   8'h01
`define REG_MEMORY_DATA     8'h02
`define REG_PIXEL_CLOCK     8'h04
`define REG_SERIAL_MEMORY   8'h05

// Field positions
`define PWR_DISPLAY_ON_BIT  7
`define PWR_SLEEP_BIT       1
`define PWR_SW_RESET_BIT    0
`define PIX_INVERT_BIT      7
`define PIX_DIV_LSB         0

// Reset values
`define RESET_INDEX         8'h00
`define RESET_DISPLAY_ON    1'h0
`define RESET_SLEEP         1'h0
`define RESET_PIX_INVERT    1'h0
`define RESET_PIX_DIV       2'h0
`define RESET_SERIAL_MEMORY 8'h00
`define UNMAPPED_READ       8'h00

// Serial read command length without dummy bytes
`define SF_BASE_BUS_BYTES   3'h4

`endif

/* core/regbank_pkg.sv */
// Purpose : Types shared by the status and system configuration bank.
// Assumes : Nothing beyond SystemVerilog packed types.
// Notes   : Struct field order gives the bit order on the host data bus.
package regbank_pkg;

  typedef struct packed {
    logic       mem_busy;
    logic       bte_busy;
    logic       touch;
    logic       sleep;
    logic [2:0] unused;
    logic       sf_busy;
  } device_status_s;

  typedef struct packed {
    logic       if_sel;
    logic       addr_mode;
    logic       wave_mode3;
    logic [1:0] read_cycle;
    logic       dma_mode;
    logic [1:0] latch_mode;
  } serial_memory_config_s;

  typedef struct packed {
    logic [2:0] bus_bytes;
    logic [1:0] dummy_bytes;
    logic       dual;
    logic       dual_mode1;
  } serial_read_format_s;

  typedef struct packed {
    logic       rw_b;
    logic       rs;
    logic [7:0] data;
  } host_pins_s;

  typedef struct packed {
    logic [1:0] target;
    logic [7:0] data;
  } mem_write_s;

  typedef enum logic [1:0] {
    HOST_IDLE,
    HOST_READ,
    HOST_WRITE
  } host_phase_e;

endpackage

/* core/mem_port_buffer.sv */
// Purpose : Small FIFO between the host data port and the memory writer.
// Assumes : Both sides on i_mclk.
// Notes   : A stalled drain side fills it and drops o_in_ready.
module mem_port_buffer #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input  logic         i_mclk,
  input  logic         i_rst_b,
  input  logic         i_clear,
  // Filling side
  input  logic         i_in_valid,
  input  logic [W-1:0] i_in_data,
  output logic         o_in_ready,
  // Draining side
  output logic         o_out_valid,
  output logic [W-1:0] o_out_data,
  input  logic         i_out_ready
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [W-1:0]  entry_reg [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic          push;
  logic          pop;

  function automatic logic [PW-1:0] next_ptr(input logic [PW-1:0] ptr);
    return (ptr == PW'(DEPTH - 1)) ? '0 : ptr + PW'(1);
  endfunction

  assign o_in_ready  = (count_reg != CW'(DEPTH));
  assign o_out_valid = (count_reg != '0);
  assign o_out_data  = entry_reg[rd_ptr_reg];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (i_clear) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= next_ptr(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= next_ptr(rd_ptr_reg);
      end
      count_reg <= count_reg + CW'(push) - CW'(pop);
    end
  end

  for (genvar i = 0; i < DEPTH; i++) begin : g_entry
    always_ff @(posedge i_mclk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        entry_reg[i] <= '0;
      end else if (push && wr_ptr_reg == PW'(i)) begin
        entry_reg[i] <= i_in_data;
      end
    end
  end

endmodule

/* core/pixel_clock_div.sv */
// Purpose : Pixel rate enable, one pulse per pixel clock period.
// Assumes : Period code may change at any time.
// Notes   : A shorter new period takes effect at once, never a long gap.
module pixel_clock_div #(
  parameter int CODE_W = 2,
  parameter int CNT_W  = 3
) (
  // Clock and reset
  input  logic              i_mclk,
  input  logic              i_rst_b,
  input  logic              i_clear,
  // Period selection and enable
  input  logic [CODE_W-1:0] i_period_code,
  output logic              o_pixel_en
);
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] limit;
  logic             terminal;

  // Period is two to the power of the code, in system clocks
  assign limit    = CNT_W'((32'h0000_0001 << i_period_code) - 32'h0000_0001);
  assign terminal = (count_reg >= limit);

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      count_reg  <= '0;
      o_pixel_en <= 1'h0;
    end else if (i_clear) begin
      count_reg  <= '0;
      o_pixel_en <= 1'h0;
    end else begin
      count_reg  <= terminal ? '0 : count_reg + CNT_W'(1);
      o_pixel_en <= terminal;
    end
  end

endmodule

/* tb/mem_far_side.sv */
// Purpose: Memory side stand-in for the register bank.
// Assumes: Same clock as the bank.
// Notes  : Write ready stalls two of every four cycles; read answer 3 clocks late.
module mem_far_side
  import regbank_pkg::*;
(
  input  wire logic       i_mclk,
  input  wire logic       i_rst_b,
  input  wire logic       i_wr_valid,
  input  wire mem_write_s i_wr,
  output logic            o_wr_ready,
  input  wire logic       i_rd_req,
  output logic            o_rd_valid,
  output logic [7:0]      o_rd_data,
  output mem_write_s      o_last_wr
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] cnt_reg;
  logic [1:0] dly_reg;
  logic [7:0] seq_reg;
  assign o_wr_ready = cnt_reg[1];
  // Idle data is the inverse so a stale byte never looks right
  assign o_rd_data = o_rd_valid ? seq_reg : ~seq_reg;
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_reg <= '0;
      dly_reg <= '0;
      seq_reg <= 8'ha0;
      o_rd_valid <= 1'b0;
      o_last_wr <= '0;
    end else begin
      cnt_reg <= cnt_reg + 2'h1;
      if (i_wr_valid && o_wr_ready) o_last_wr <= i_wr;
      dly_reg <= i_rd_req ? 2'h2 : (dly_reg != 2'h0 ? dly_reg - 2'h1 : 2'h0);
      o_rd_valid <= (dly_reg == 2'h1);
      if (o_rd_valid) seq_reg <= seq_reg + 8'h01;
    end
  end
endmodule

/* tb/tb_status_and_system_config_regs.sv */
// Purpose: Self-checking bench of the status and configuration bank.
// Assumes: Host cycles hold chip select low 9 clocks, high 7.
// Notes  : Random values from a fixed-seed shift register.
`include "regbank_consts.svh"
module tb_status_and_system_config_regs
  import regbank_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_b, cs_b, rw_b, rs, tch, block_transfer_engine, sf, tw, kw, rdy, rdv, fb, i2c;
  logic oe, wt_b, wv, rq, disp, slp, srst, pen, pfe;
  logic [7:0] db, odb, rdd, v, e;
  logic [1:0] tgt;
  logic [31:0] rnd;
  mem_write_s wr, last;
  serial_memory_config_s smc;
  serial_read_format_s srf;
  int error_cnt, checked, n, cnt, nsr;
  status_and_system_config_regs uut (.i_mclk(clk), .i_rst_b(rst_b), .i_cs_b(cs_b),
    .i_rw_b(rw_b), .i_rs(rs), .i_db(db), .o_db(odb), .o_db_oe(oe), .o_wait_b(wt_b),
    .i_i2c_mode(i2c), .i_touch_detect_raw(tch), .i_mem_target(tgt), .o_mem_wr_valid(wv),
    .o_mem_wr(wr), .i_mem_wr_ready(rdy), .o_mem_rd_req(rq), .i_mem_rd_valid(rdv),
    .i_mem_rd_data(rdd), .i_font_busy(fb), .i_bte_busy(block_transfer_engine), .i_sf_busy(sf),
    .i_touch_wake(tw), .i_key_wake(kw), .o_display_on(disp), .o_sleep(slp),
    .o_soft_reset(srst), .o_pixel_en(pen), .o_pixel_fall_edge(pfe),
    .o_serial_memory_config(smc), .o_serial_read_format(srf));
  mem_far_side far (.i_mclk(clk), .i_rst_b(rst_b), .i_wr_valid(wv), .i_wr(wr),
    .o_wr_ready(rdy), .i_rd_req(rq), .o_rd_valid(rdv), .o_rd_data(rdd), .o_last_wr(last));
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [6:0] fmt(input logic [7:0] c);
    return {c[4] ? 3'h6 : (c[3] ? 3'h5 : 3'h4), c[4] ? 2'h2 : {1'b0, c[3]}, c[1], c[1] & c[0]};
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    checked++;
    if (g !== x) begin
      error_cnt++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic cyc(input logic w, input logic r, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    cs_b <= 1'b0;
    rw_b <= w;
    rs <= r;
    db <= d;
    repeat (9) @(posedge clk);
    for (int i = 0; i < 40 && wt_b !== 1'b1; i++) @(posedge clk);
    q = odb;
    chk(16'({oe, wt_b}), 16'({w, 1'b1}));
    cs_b <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    cyc(1'b0, 1'b1, a, v);
    cyc(1'b0, 1'b0, d, v);
  endtask
  task automatic rreg(input logic [7:0] a);
    cyc(1'b0, 1'b1, a, v);
    cyc(1'b1, 1'b0, 8'h00, v);
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Counts software reset pulses on the bank's o_soft_reset output
  always @(posedge clk) if (srst === 1'b1) nsr++;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #200_000;
    error_cnt++;
    give_verdict();
  end
  initial begin
    {rst_b, rw_b, rs, tch, block_transfer_engine, sf, tw, kw, fb, i2c, db, tgt} = '0;
    cs_b = 1'b1;
    rnd = 32'hd0b5_2061;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    foreach (e[k]) if (k < 4) begin
      rreg(k == 0 ? 8'h01 : 8'h03 + 8'(k));
      chk(v, 8'h00);
    end
    $display("reset value test done");
    for (n = 0; n < 6; n++) begin
      rnd = lfsr(rnd);
      {fb, block_transfer_engine, sf, tch} <= rnd[3:0];
      cyc(1'b1, 1'b1, 8'h00, v);
      chk(v, {rnd[3], rnd[2], rnd[0], 4'h0, rnd[1]});
    end
    {fb, block_transfer_engine, sf, tch} <= 4'h0;
    $display("status test done");
    for (n = 0; n < 4; n++) begin
      rnd = lfsr(rnd);
      e = {rnd[7], 5'h00, n[1:0]};
      wreg(`REG_PIXEL_CLOCK, e);
      rreg(`REG_PIXEL_CLOCK);
      chk({v, 7'h00, pfe}, {e, 7'h00, e[7]});
      cnt = 0;
      repeat (32) begin
        @(posedge clk);
        #1 cnt += int'(pen);
      end
      chk(16'(cnt), 16'h0020 >> n);
      e = {rnd[9], 1'b0, rnd[8], n[1:0], rnd[10], n[1:0]};
      wreg(`REG_SERIAL_MEMORY, e);
      rreg(`REG_SERIAL_MEMORY);
      chk({v, 1'b0, srf}, {e, 1'b0, fmt(e)});
      chk(16'(smc), 16'(e));
    end
    $display("pixel and serial test done");
    for (n = 0; n < 3; n++) begin
      wreg(`REG_POWER_DISPLAY, 8'h82);
      cyc(1'b1, 1'b1, 8'h00, v);
      chk(v, 8'h10);
      if (n == 2) wreg(`REG_POWER_DISPLAY, 8'h80);
      else begin
        {kw, tw} <= n[0] ? 2'h1 : 2'h2;
        @(posedge clk);
        {kw, tw} <= 2'h0;
        repeat (3) @(posedge clk);
      end
      chk({disp, slp}, 16'h0002);
    end
    // Sleep request over the two-wire link must be ignored
    i2c <= 1'b1;
    wreg(`REG_POWER_DISPLAY, 8'h02);
    chk({disp, slp}, 16'h0000);
    i2c <= 1'b0;
    $display("sleep test done");
    cyc(1'b0, 1'b1, `REG_MEMORY_DATA, v);
    for (n = 0; n < 4; n++) begin
      rnd = lfsr(rnd);
      tgt <= rnd[9:8];
      cyc(1'b0, 1'b0, rnd[7:0], v);
      repeat (2) @(posedge clk);
      chk(16'(last), 16'(rnd[9:0]));
    end
    cyc(1'b1, 1'b0, 8'h00, v);
    cyc(1'b1, 1'b0, 8'h00, v);
    chk(v, 8'ha0);
    cyc(1'b1, 1'b0, 8'h00, v);
    chk(v, 8'ha1);
    $display("memory port test done");
    wreg(`REG_PIXEL_CLOCK, 8'h83);
    wreg(`REG_POWER_DISPLAY, 8'h81);
    wreg(`REG_POWER_DISPLAY, 8'h00);
    rreg(`REG_PIXEL_CLOCK);
    chk({v, 7'h00, pfe}, 16'h0000);
    chk(16'(nsr), 16'h0001);
    $display("software reset test done");
    give_verdict();
  end
endmodule
